// ==== verilog/period_match_timer.sv ====
// Purpose: Eight-bit period timer with prescaler, match flag and interrupt.
// Assumes: Zero-wait AHB-Lite slave, word accesses only, clock mclk at 50 MHz.
// Notes: Sleep freezes the whole timer, prescaler included.
// Functional notes
// - Eight-bit up-counter and period register, prescaler fed by the system clock.
// - Counter advances once per prescaler output pulse only.
// - Count starts at zero and wraps to zero on the increment after equality.
// - A prescaler tick while count equals period sets the match flag.
// - Count and period are readable and writable at any time.
// - Any reset loads count with zero and period with all ones.
// - Counter runs only while the run bit is one, else holds.
// - Prescale select picks divide by 1, 4, 8 or 16.
// - Count writes, control writes and reset clear the prescaler.
// - A control write leaves the count unchanged.
// - Upper 29 control bits read zero and ignore writes.
// - During sleep the timer state freezes and resumes afterwards.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sleep,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq
);

	// Bus slave.
	period_match_timer_pkg::bus_state_t state_r;
	period_match_timer_pkg::bus_state_t state_nxt;
	period_match_timer_pkg::addr_phase_t addrQ_r;
	period_match_timer_pkg::addr_phase_t addrQ_nxt;

	wire takeReq = hsel & hready & htrans[1];
	wire sizeWord = (hsize == 3'h2);

	assign addrQ_nxt.addr = haddr;
	assign addrQ_nxt.write = hwrite;

	always_comb begin
		state_nxt = period_match_timer_pkg::BUS_IDLE;
		if (takeReq && hwrite && sizeWord) begin
			state_nxt = period_match_timer_pkg::BUS_WR;
		end else if (takeReq && !hwrite) begin
			state_nxt = period_match_timer_pkg::BUS_RD;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= period_match_timer_pkg::BUS_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addrQ_r <= '0;
		end else if (takeReq) begin
			addrQ_r <= addrQ_nxt;
		end
	end

	wire inWrite = (state_r == period_match_timer_pkg::BUS_WR);
	wire inRead = (state_r == period_match_timer_pkg::BUS_RD);
	wire selCount = (addrQ_r.addr == period_match_timer_pkg::OFF_COUNT);
	wire selPeriod = (addrQ_r.addr == period_match_timer_pkg::OFF_PERIOD);
	wire selCtrl = (addrQ_r.addr == period_match_timer_pkg::OFF_CTRL);
	wire selEnables = (addrQ_r.addr == period_match_timer_pkg::OFF_ENABLES);
	wire selFlags = (addrQ_r.addr == period_match_timer_pkg::OFF_FLAGS);
	wire selFlagClr = (addrQ_r.addr == period_match_timer_pkg::OFF_FLAG_CLR);

	wire wrCount = inWrite & selCount;
	wire wrPeriod = inWrite & selPeriod;
	wire wrCtrl = inWrite & selCtrl;
	wire wrEnables = inWrite & selEnables;
	wire wrFlags = inWrite & selFlags;
	wire wrFlagClr = inWrite & selFlagClr;

	// The slave never stalls, so every access completes in one data phase.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Timer state.
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic [7:0] period_r;
	period_match_timer_pkg::ctrl_t ctrl_r;
	period_match_timer_pkg::ctrl_t ctrl_nxt;
	logic matchEn_r;
	logic matchFlag_r;
	logic matchFlag_nxt;
	logic [3:0] terminal;
	logic tick;

	always_comb begin
		case (ctrl_r.psel)
			period_match_timer_pkg::PSEL_DIV1: terminal = period_match_timer_pkg::TERM_DIV1;
			period_match_timer_pkg::PSEL_DIV4: terminal = period_match_timer_pkg::TERM_DIV4;
			period_match_timer_pkg::PSEL_DIV8: terminal = period_match_timer_pkg::TERM_DIV8;
			default: terminal = period_match_timer_pkg::TERM_DIV16;
		endcase
	end

	// Sleep gates the prescaler too, so a wake-up resumes mid-period.
	wire advance = ctrl_r.run & ~sleep;
	wire preClear = wrCount | wrCtrl;

	// The prescaler runs straight from mclk, the system clock.
	prescale_divider #(
		.CNT_W(4)
	) u_prescale (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(preClear),
		.advance(advance),
		.terminal(terminal),
		.tick(tick)
	);

	wire atMatch = (count_r == period_r);
	wire wrapEvent = tick & atMatch;

	always_comb begin
		count_nxt = count_r;
		if (wrCount) begin
			count_nxt = hwdata[7:0];
		end else if (wrapEvent) begin
			count_nxt = 8'h00;
		end else if (tick) begin
			count_nxt = count_r + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_r <= period_match_timer_pkg::COUNT_RST;
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			period_r <= period_match_timer_pkg::PERIOD_RST;
		end else if (wrPeriod) begin
			period_r <= hwdata[7:0];
		end
	end

	// Only the three low bits are stored; the rest are never kept.
	assign ctrl_nxt.run = hwdata[period_match_timer_pkg::RUN_BIT];
	assign ctrl_nxt.psel = hwdata[period_match_timer_pkg::PSEL_LSB +: 2];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_r <= '0;
		end else if (wrCtrl) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			matchEn_r <= period_match_timer_pkg::ENABLES_RST[period_match_timer_pkg::MATCH_BIT];
		end else if (wrEnables) begin
			matchEn_r <= hwdata[period_match_timer_pkg::MATCH_BIT];
		end
	end

	// Writing zero to the flag or one to the clear word clears it.
	wire clrFlag = (wrFlags & ~hwdata[period_match_timer_pkg::MATCH_BIT])
		| (wrFlagClr & hwdata[period_match_timer_pkg::MATCH_BIT]);

	// A match in the same cycle as a clear must not be lost, so set wins.
	assign matchFlag_nxt = wrapEvent | (matchFlag_r & ~clrFlag);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			matchFlag_r <= 1'b0;
		end else begin
			matchFlag_r <= matchFlag_nxt;
		end
	end

	assign irq = matchFlag_r & matchEn_r;

	// Read data.
	wire [31:0] rdCount = {24'h0, count_r};
	wire [31:0] rdPeriod = {24'h0, period_r};
	wire [31:0] rdCtrl = {29'h0, ctrl_r.run, ctrl_r.psel};
	wire [31:0] rdEnables = {30'h0, matchEn_r, 1'b0};
	wire [31:0] rdFlags = {30'h0, matchFlag_r, 1'b0};

	always_comb begin
		hrdata = 32'h0000_0000;
		if (inRead && selCount) begin
			hrdata = rdCount;
		end else if (inRead && selPeriod) begin
			hrdata = rdPeriod;
		end else if (inRead && selCtrl) begin
			hrdata = rdCtrl;
		end else if (inRead && selEnables) begin
			hrdata = rdEnables;
		end else if (inRead && selFlags) begin
			hrdata = rdFlags;
		end
	end

	// Checks.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence ctrlDiv4Run;
		wrCtrl && hwdata[2:0] == 3'b101;
	endsequence

	sequence quietCycle;
		!sleep && !wrCtrl && !wrCount;
	endsequence

	chk_reset_values: assert property (
		$rose(rst_n) |-> count_r == 8'h00 && period_r == 8'hff)
		else $error("Timer registers left reset with wrong values.");

	chk_count_wrap: assert property (
		tick && atMatch && !wrCount |=> count_r == 8'h00 && matchFlag_r)
		else $error("Count did not wrap to zero with flag on match.");

	chk_count_step: assert property (
		tick && !atMatch && !wrCount |=> count_r == $past(count_r) + 8'h01)
		else $error("Count did not advance by one on a tick.");

	chk_count_hold: assert property (
		!tick && !wrCount |=> count_r == $past(count_r))
		else $error("Count changed without a tick or a count write.");

	chk_count_write: assert property (
		wrCount |=> count_r == $past(hwdata[7:0]))
		else $error("Count write did not replace the value.");

	chk_run_gate: assert property (
		(!ctrl_r.run || sleep) |-> !tick)
		else $error("Prescaler ticked while stopped or asleep.");

	chk_div_ratio: assert property (
		ctrlDiv4Run ##1 quietCycle [*4] |-> tick && !$past(tick, 1)
			&& !$past(tick, 2) && !$past(tick, 3))
		else $error("Divide by four did not tick on the fourth cycle.");

	chk_prescale_clear: assert property (
		wrCount && ctrl_r.psel != 2'h0 |=> !tick)
		else $error("Prescaler was not cleared by a count write.");

	chk_flag_sticky: assert property (
		matchFlag_r && !clrFlag |=> matchFlag_r [*1] ##0 (irq == matchEn_r))
		else $error("Match flag dropped or interrupt not gated by enable.");

	chk_ctrl_zeros: assert property (
		inRead && selCtrl |-> hrdata[31:3] == 29'h0)
		else $error("Unimplemented control bits read as nonzero.");

	sequence nonWordWrite;
		takeReq && hwrite && !sizeWord;
	endsequence

	sequence ctrlDiv1Run;
		wrCtrl && hwdata[2:0] == 3'b100;
	endsequence

	sequence ctrlDiv8Run;
		wrCtrl && hwdata[2:0] == 3'b110;
	endsequence

	chk_period_write: assert property (
		wrPeriod |=> period_r == $past(hwdata[7:0]))
		else $error("Period write did not replace the value.");

	chk_period_hold: assert property (
		!wrPeriod |=> period_r == $past(period_r))
		else $error("Period changed without a period write.");

	chk_ctrl_keeps_count: assert property (
		wrCtrl && !tick |=> count_r == $past(count_r))
		else $error("Control write disturbed the count.");

	chk_ctrl_clears_pre: assert property (
		wrCtrl |=> !tick || ctrl_r.psel == 2'h0)
		else $error("Prescaler was not cleared by a control write.");

	chk_flag_set: assert property (
		wrapEvent |=> matchFlag_r)
		else $error("Match did not set the flag.");

	chk_flag_clear: assert property (
		clrFlag && !wrapEvent |=> !matchFlag_r)
		else $error("Flag clear was not obeyed.");

	chk_flag_stays_low: assert property (
		!matchFlag_r && !wrapEvent |=> !matchFlag_r)
		else $error("Flag set without a match.");

	chk_irq_needs_enable: assert property (
		irq |-> matchFlag_r && matchEn_r)
		else $error("Interrupt raised without flag and enable.");

	chk_irq_raised: assert property (
		matchFlag_r && matchEn_r |-> irq)
		else $error("Interrupt missing while flag and enable are set.");

	chk_sleep_freeze: assert property (
		sleep && !wrCount |=> count_r == $past(count_r))
		else $error("Count changed during sleep.");

	chk_rdata_idle: assert property (
		!inRead |-> hrdata == 32'h0000_0000)
		else $error("Read data driven outside a read data phase.");

	chk_bus_direction: assert property (
		inWrite || inRead |-> addrQ_r.write == inWrite)
		else $error("Data phase direction differs from the address phase.");

	chk_byte_write: assert property (
		nonWordWrite |=> !inWrite)
		else $error("Non-word write was not ignored.");

	chk_div1_ratio: assert property (
		ctrlDiv1Run ##1 quietCycle |-> tick)
		else $error("Divide by one did not tick in the first cycle.");

	chk_div8_ratio: assert property (
		ctrlDiv8Run ##1 quietCycle [*8] |-> tick && !$past(tick, 1)
			&& !$past(tick, 2) && !$past(tick, 3) && !$past(tick, 4)
			&& !$past(tick, 5) && !$past(tick, 6) && !$past(tick, 7))
		else $error("Divide by eight did not tick on the eighth cycle.");

	chk_clear_reads_zero: assert property (
		inRead && selFlagClr |-> hrdata == 32'h0000_0000)
		else $error("Flag clear word did not read as zero.");

	chk_flag_layout: assert property (
		inRead && (selEnables || selFlags) |-> hrdata[31:2] == 30'h0 && !hrdata[0])
		else $error("Enable or flag word read unused bits as nonzero.");

endmodule // period_match_timer
`default_nettype wire

// ==== include/period_match_timer_pkg.sv ====
// Purpose: Shared constants and types for the period match timer.
// Assumes: One 50 MHz system clock and an AHB-Lite register bus.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package period_match_timer_pkg;

	// Register byte offsets.
	localparam logic [31:0] OFF_COUNT = 32'h0000_0000;
	localparam logic [31:0] OFF_PERIOD = 32'h0000_0004;
	localparam logic [31:0] OFF_CTRL = 32'h0000_0008;
	localparam logic [31:0] OFF_ENABLES = 32'h0000_000c;
	localparam logic [31:0] OFF_FLAGS = 32'h0000_0010;
	localparam logic [31:0] OFF_FLAG_CLR = 32'h0000_0014;

	// Reset values.
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [7:0] ENABLES_RST = 8'h00;

	// Field positions.
	localparam int RUN_BIT = 2;
	localparam int PSEL_LSB = 0;
	localparam int MATCH_BIT = 1;

	// Prescaler terminal counts, one less than the divide ratio.
	localparam logic [3:0] TERM_DIV1 = 4'h0;
	localparam logic [3:0] TERM_DIV4 = 4'h3;
	localparam logic [3:0] TERM_DIV8 = 4'h7;
	localparam logic [3:0] TERM_DIV16 = 4'hf;

	// Prescale select encodings.
	localparam logic [1:0] PSEL_DIV1 = 2'h0;
	localparam logic [1:0] PSEL_DIV4 = 2'h1;
	localparam logic [1:0] PSEL_DIV8 = 2'h2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic run;
		logic [1:0] psel;
	} ctrl_t;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
	} addr_phase_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WR = 3'b010,
		BUS_RD = 3'b100
	} bus_state_t;

endpackage

// ==== verilog/prescale_divider.sv ====
// Purpose: Divides the system clock into single-cycle advance ticks.
// Assumes: The terminal count only changes together with a clear.
// Notes: Holds its count while advance is low.
`timescale 1ns/1ps
`default_nettype none
module prescale_divider #(
	parameter int CNT_W = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic advance,
	input wire logic [CNT_W-1:0] terminal,
	output logic tick
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	wire atTerm = (cnt_r == terminal);

	assign tick = advance & atTerm;
	assign cnt_nxt = atTerm ? '0 : cnt_r + 1'b1;

	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			cnt_r <= '0;
		end else if (advance) begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // prescale_divider
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Register-level test of the period match timer over AHB-Lite.
// Assumes: One slave, whose hreadyout is the bus hready; sleep freezes the count for reads.
// Notes: Counts are read while asleep or stopped, so reading never races an increment.
`timescale 1ns/1ps
`default_nettype none
`define R(x) period_match_timer_pkg::x
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
	logic mclk, rst_n, sleep, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	int miscompares, checkCount;
	int ratio [4] = '{1, 4, 8, 16};
	logic [2:0] xferSize = 3'h2;
	assign hready = hreadyout;
	period_match_timer period_match_timer_inst (
		.mclk(mclk), .rst_n(rst_n), .sleep(sleep), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq)
	);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic waitReady();
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		if (hreadyout !== 1'b1) begin
			miscompares++;
			$display("BAD hreadyout exp 1 got timeout");
			conclude();
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= `R(HTRANS_NONSEQ);
		hwrite <= w;
		hsize <= xferSize;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		q = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask
	task automatic chkIrq(input logic e);
		@(negedge mclk);
		`CHK("irq", e, irq)
		// Return on a rising edge so that the next request starts right after it.
		@(posedge mclk);
	endtask
	// Lets the timer advance for exactly k cycles, then freezes it again.
	task automatic pulse(input int k);
		sleep <= 1'b0;
		repeat (k) @(posedge mclk);
		sleep <= 1'b1;
	endtask
	task automatic runFor(input logic [31:0] per, input logic [31:0] ctrl, input int k);
		sleep <= 1'b0;
		wr(`R(OFF_CTRL), 32'h0);
		wr(`R(OFF_FLAG_CLR), 32'h2);
		wr(`R(OFF_PERIOD), per);
		wr(`R(OFF_COUNT), 32'h0);
		wr(`R(OFF_CTRL), ctrl);
		pulse(k);
	endtask
	initial begin
		rst_n = 1'b0;
		sleep = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		miscompares = 0;
		checkCount = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rdchk("count reset", `R(OFF_COUNT), 32'h00);
		rdchk("period reset", `R(OFF_PERIOD), 32'hff);
		rdchk("ctrl reset", `R(OFF_CTRL), 32'h0);
		rdchk("flags reset", `R(OFF_FLAGS), 32'h0);
		chkIrq(1'b0);
		$display("test reset done");
		wr(`R(OFF_CTRL), 32'hffff_fff8);
		rdchk("ctrl upper", `R(OFF_CTRL), 32'h0);
		wr(`R(OFF_CTRL), 32'hff);
		rdchk("ctrl mask", `R(OFF_CTRL), 32'h7);
		wr(`R(OFF_CTRL), 32'h0);
		wr(`R(OFF_PERIOD), 32'h5a);
		wr(`R(OFF_COUNT), 32'h33);
		repeat (20) @(posedge mclk);
		rdchk("period rw", `R(OFF_PERIOD), 32'h5a);
		rdchk("count held", `R(OFF_COUNT), 32'h33);
		xferSize = 3'h0;
		wr(`R(OFF_PERIOD), 32'h11);
		xferSize = 3'h2;
		rdchk("byte write ignored", `R(OFF_PERIOD), 32'h5a);
		wr(32'h40, 32'h12);
		rdchk("unmapped", 32'h40, 32'h0);
		$display("test registers done");
		runFor(32'h2, 32'h4, 2);
		rdchk("count at period", `R(OFF_COUNT), 32'h2);
		rdchk("no match yet", `R(OFF_FLAGS), 32'h0);
		runFor(32'h2, 32'h4, 3);
		rdchk("count wrapped", `R(OFF_COUNT), 32'h0);
		rdchk("match set", `R(OFF_FLAGS), 32'h2);
		chkIrq(1'b0);
		wr(`R(OFF_ENABLES), 32'h2);
		chkIrq(1'b1);
		wr(`R(OFF_FLAGS), 32'hff);
		rdchk("flag sticks", `R(OFF_FLAGS), 32'h2);
		wr(`R(OFF_ENABLES), 32'h0);
		chkIrq(1'b0);
		wr(`R(OFF_ENABLES), 32'h2);
		wr(`R(OFF_FLAG_CLR), 32'h2);
		rdchk("flag cleared", `R(OFF_FLAGS), 32'h0);
		chkIrq(1'b0);
		runFor(32'h2, 32'h4, 3);
		chkIrq(1'b1);
		wr(`R(OFF_FLAGS), 32'h0);
		rdchk("flag written 0", `R(OFF_FLAGS), 32'h0);
		chkIrq(1'b0);
		$display("test match done");
		for (int i = 0; i < 4; i++) begin
			runFor(32'hff, 32'h4 | i, 35);
			rdchk("prescaled", `R(OFF_COUNT), 32'(35 / ratio[i]));
		end
		$display("test prescale done");
		runFor(32'hff, 32'h5, 6);
		rdchk("div4 count", `R(OFF_COUNT), 32'h1);
		repeat (10) @(posedge mclk);
		rdchk("asleep", `R(OFF_COUNT), 32'h1);
		wr(`R(OFF_CTRL), 32'h5);
		rdchk("ctrl write keeps", `R(OFF_COUNT), 32'h1);
		pulse(3);
		rdchk("ctrl clears pre", `R(OFF_COUNT), 32'h1);
		pulse(1);
		rdchk("resumed", `R(OFF_COUNT), 32'h2);
		wr(`R(OFF_COUNT), 32'h20);
		pulse(3);
		rdchk("count clears pre", `R(OFF_COUNT), 32'h20);
		pulse(1);
		rdchk("count tick", `R(OFF_COUNT), 32'h21);
		$display("test sleep and clear done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
